// *** common/jtb_pkg.sv ***
// constants shared by the test access port: tap codes, scan chain size and cell reset image
// assumes a single top module that imports this package whole
//
// What this block does
// - sixteen state tap machine selects scan mode
// - test reset low holds tap in reset
// - open tms, tck, tdi, reset read high
// - chain order fixed from tdi toward tdo
// - cells per pin: one, two, three
// - cells take fixed initialization values
// - three bit instruction, lsb first, bypass default
// - test logic reset loads identification instruction
// - capture ir loads internal test code
// - 32 bit identification register, lsb one
package jtb_pkg;

  // ****************************************************************
  // instruction register
  // ****************************************************************
  localparam int unsigned IR_W         = 3;
  localparam logic [2:0]  IR_EXTEST    = 3'h0;
  localparam logic [2:0]  IR_INTEST    = 3'h1;
  localparam logic [2:0]  IR_SAMPLE    = 3'h2;
  localparam logic [2:0]  IR_IDCODE    = 3'h3;
  localparam logic [2:0]  IR_BYPASS    = 3'h7;

  // ****************************************************************
  // identification and scan chain
  // ****************************************************************
  localparam int unsigned ID_W         = 32;
  localparam int unsigned CELLS        = 158;
  localparam int unsigned SYNC_STAGES  = 3;
  // bit 157 is the cell next to tdi, bit 0 the cell next to tdo
  localparam logic [157:0] CELL_INIT   = {36'h9002f840c, 122'h0};

  // ****************************************************************
  // tap states, one-hot
  // ****************************************************************
  typedef enum logic [15:0] {
    TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
    SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
    UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
    E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
  } jtb_state_t;

endpackage

// *** src/jtb_tap_top.sv ***
// test access port with boundary scan chain, tck domain at the pins, core domain inside
// assumes pad pull-ups on tms, tck, tdi and test reset; the pad resolves tdo from tdo_oe_o
`timescale 1ns/1ps
module jtb_tap_top
  import jtb_pkg::*;
#(
  parameter int unsigned  N         = CELLS,
  parameter logic [3:0]   ID_VER    = 4'h1,     // arbitrary value
  parameter logic [15:0]  ID_PART   = 16'h1234, // arbitrary value
  parameter logic [10:0]  ID_MAKER  = 11'h155   // arbitrary value
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          tck_i,
  input  wire logic          trst_n_i,
  input  wire logic          tms_i,
  input  wire logic          tdi_i,
  output logic               tdo_o,
  output logic               tdo_oe_o,
  input  wire logic [N-1:0]  cell_capture_i,
  output logic      [N-1:0]  cell_drive_o,
  output logic               test_extest_o,
  output logic               test_intest_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // a synchronised level counts only once the second and third stage agree
  function automatic logic agreed(input logic s2, input logic s3, input logic prev);
    agreed = (s2 == s3) ? s3 : prev;
  endfunction

  function automatic logic is_boundary(input logic [2:0] code);
    is_boundary = (code == IR_EXTEST) || (code == IR_INTEST) || (code == IR_SAMPLE);
  endfunction

  localparam logic [ID_W-1:0] ID_WORD = {ID_VER, ID_PART, ID_MAKER, 1'b1};

  // ****************************************************************
  // tap state machine (tck domain)
  // ****************************************************************
  jtb_state_t state_ff;
  jtb_state_t nxt_state;

  // an undriven tms reads high through the pad, so a floating port walks to reset
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TLR:  nxt_state = tms_i ? TLR  : RTI;
      RTI:  nxt_state = tms_i ? SDRS : RTI;
      SDRS: nxt_state = tms_i ? SIRS : CDR;
      CDR:  nxt_state = tms_i ? E1DR : SDR;
      SDR:  nxt_state = tms_i ? E1DR : SDR;
      E1DR: nxt_state = tms_i ? UDR  : PDR;
      PDR:  nxt_state = tms_i ? E2DR : PDR;
      E2DR: nxt_state = tms_i ? UDR  : SDR;
      UDR:  nxt_state = tms_i ? SDRS : RTI;
      SIRS: nxt_state = tms_i ? TLR  : CIR;
      CIR:  nxt_state = tms_i ? E1IR : SIR;
      SIR:  nxt_state = tms_i ? E1IR : SIR;
      E1IR: nxt_state = tms_i ? UIR  : PIR;
      PIR:  nxt_state = tms_i ? E2IR : PIR;
      E2IR: nxt_state = tms_i ? UIR  : SIR;
      UIR:  nxt_state = tms_i ? SDRS : RTI;
      default: nxt_state = TLR;
    endcase
  end

  // test reset low pins the machine in reset whatever tck does
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_ff <= TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // instruction register
  // ****************************************************************
  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] ir_ff;

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ir_sh_ff <= IR_IDCODE;
    end else if (state_ff == CIR) begin
      ir_sh_ff <= IR_INTEST;
    end else if (state_ff == SIR) begin
      ir_sh_ff <= {tdi_i, ir_sh_ff[IR_W-1:1]};  // lsb leaves first
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ir_ff <= IR_IDCODE;
    end else if (state_ff == TLR) begin
      ir_ff <= IR_IDCODE;
    end else if (state_ff == UIR) begin
      ir_ff <= ir_sh_ff;  // unlisted codes fall to bypass in the data mux
    end
  end

  // ****************************************************************
  // data registers: bypass, identification, boundary
  // ****************************************************************
  logic            byp_ff;
  logic [ID_W-1:0] id_sh_ff;
  logic [N-1:0]    bs_sh_ff;
  logic [N-1:0]    upd_ff;
  logic [N-1:0]    cap_ff;
  logic            upd_tgl_ff;
  logic            sel_bs;
  logic            sel_id;

  assign sel_bs = is_boundary(ir_ff);
  assign sel_id = (ir_ff == IR_IDCODE);

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      byp_ff <= 1'b0;
    end else if (state_ff == CDR) begin
      byp_ff <= 1'b0;
    end else if (state_ff == SDR) begin
      byp_ff <= tdi_i;  // one tck of delay in bypass
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      id_sh_ff <= '0;
    end else if (state_ff == CDR && sel_id) begin
      id_sh_ff <= ID_WORD;
    end else if (state_ff == SDR && sel_id) begin
      id_sh_ff <= {tdi_i, id_sh_ff[ID_W-1:1]};
    end
  end

  // tdi enters the cell beside it; bit 0 sits beside tdo
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      bs_sh_ff <= CELL_INIT;
    end else if (state_ff == CDR && sel_bs) begin
      bs_sh_ff <= cap_ff;
    end else if (state_ff == SDR && sel_bs) begin
      bs_sh_ff <= {tdi_i, bs_sh_ff[N-1:1]};
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      upd_ff     <= CELL_INIT;
      upd_tgl_ff <= 1'b0;
    end else if (state_ff == TLR) begin
      upd_ff     <= CELL_INIT;
    end else if (state_ff == UDR && sel_bs) begin
      upd_ff     <= bs_sh_ff;
      upd_tgl_ff <= ~upd_tgl_ff;
    end
  end

  // ****************************************************************
  // tdo on the falling edge
  // ****************************************************************
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_oe_o <= (state_ff == SIR) || (state_ff == SDR);
      if (state_ff == SIR) begin
        tdo_o <= ir_sh_ff[0];
      end else if (state_ff == SDR) begin
        tdo_o <= sel_bs ? bs_sh_ff[0] : (sel_id ? id_sh_ff[0] : byp_ff);
      end
    end
  end

  // ****************************************************************
  // capture snapshot crossing: core -> tck, toggle handshake
  // ****************************************************************
  // a snapshot may be a few core cycles old when captured; pin levels are static in board test
  logic [N-1:0] hold_ff;
  logic         req_ff;
  logic [2:0]   req_sync_ff;
  logic         ack_ff;
  logic [2:0]   ack_sync_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ff     <= '0;
      req_ff      <= 1'b0;
      ack_sync_ff <= '0;
    end else if (ce_i) begin
      ack_sync_ff <= {ack_sync_ff[1:0], ack_ff};
      if (ack_sync_ff[1] == ack_sync_ff[2] && ack_sync_ff[2] == req_ff) begin
        hold_ff <= cell_capture_i;
        req_ff  <= ~req_ff;
      end
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      req_sync_ff <= '0;
      ack_ff      <= 1'b0;
      cap_ff      <= '0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], req_ff};
      if (req_sync_ff[1] == req_sync_ff[2] && req_sync_ff[2] != ack_ff) begin
        cap_ff <= hold_ff;
        ack_ff <= req_sync_ff[2];
      end
    end
  end

  // ****************************************************************
  // update and mode crossing: tck -> core
  // ****************************************************************
  logic       ext_mode_ff;
  logic       int_mode_ff;
  logic [2:0] ext_sync_ff;
  logic [2:0] int_sync_ff;
  logic [2:0] upd_sync_ff;
  logic       upd_seen_ff;

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ext_mode_ff <= 1'b0;
      int_mode_ff <= 1'b0;
    end else if (nxt_state == TLR) begin
      // tms held high lands in reset, which clears both modes
      ext_mode_ff <= 1'b0;
      int_mode_ff <= 1'b0;
    end else if (state_ff == UIR) begin
      // follow the code latched at this edge; tck may stop right after update-ir
      ext_mode_ff <= (ir_sh_ff == IR_EXTEST);
      int_mode_ff <= (ir_sh_ff == IR_INTEST);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync_ff   <= '0;
      int_sync_ff   <= '0;
      test_extest_o <= 1'b0;
      test_intest_o <= 1'b0;
    end else if (ce_i) begin
      ext_sync_ff   <= {ext_sync_ff[1:0], ext_mode_ff};
      int_sync_ff   <= {int_sync_ff[1:0], int_mode_ff};
      test_extest_o <= agreed(ext_sync_ff[1], ext_sync_ff[2], test_extest_o);
      test_intest_o <= agreed(int_sync_ff[1], int_sync_ff[2], test_intest_o);
    end
  end

  // upd_ff is stable for many tck cycles after its toggle, so the word is read whole
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_sync_ff  <= '0;
      upd_seen_ff  <= 1'b0;
      cell_drive_o <= CELL_INIT;
    end else if (ce_i) begin
      upd_sync_ff <= {upd_sync_ff[1:0], upd_tgl_ff};
      if (agreed(upd_sync_ff[1], upd_sync_ff[2], upd_seen_ff) != upd_seen_ff) begin
        upd_seen_ff  <= upd_sync_ff[2];
        cell_drive_o <= upd_ff;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_reach_shift_dr;
    (state_ff == TLR && !tms_i) ##1 tms_i ##1 !tms_i ##1 !tms_i;
  endsequence

  sequence s_five_high;
    tms_i [*5];
  endsequence

  a_state_onehot: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    $onehot(state_ff)) else $error("tap state is not one-hot");

  a_tms_reset_walk: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    s_five_high |=> state_ff == TLR) else $error("five tms highs did not reach reset");

  a_idcode_entry: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    s_reach_shift_dr |=> (state_ff == SDR && ir_ff == IR_IDCODE))
    else $error("reset path did not shift identification");

  a_capir_intest: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    state_ff == CIR |=> ir_sh_ff == IR_INTEST) else $error("capture ir lost internal code");

  a_ir_shift_lsb: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    state_ff == SIR |=> ir_sh_ff[2] == $past(tdi_i)) else $error("ir shift order wrong");

  a_bypass_delay: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (state_ff == SDR && !tms_i && !sel_bs && !sel_id) |=> tdo_o == $past(tdi_i))
    else $error("bypass bit not one tck late");

  a_idcode_lsb: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (state_ff == CDR && sel_id) ##1 state_ff == SDR |-> tdo_o == 1'b1)
    else $error("identification lsb not one");

  a_tdo_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tdo_oe_o == (state_ff == SIR || state_ff == SDR)) else $error("tdo enable outside shift");

  a_reset_cells: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    state_ff == TLR |=> upd_ff == CELL_INIT) else $error("reset did not restore cell values");

endmodule

// *** sim/jtb_tester.sv ***
// board test controller model: makes tck and drives tms and tdi
// assumes the tap samples tms and tdi on tck rising and moves tdo on tck falling
`timescale 1ns/1ps
module jtb_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  // ****************************************************************
  // link cycles
  // ****************************************************************
  // tck stands low between frames; idle levels are what the pull-ups give
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // one 15 ns cycle; levels move only after the falling edge
  task automatic tick(input logic m, input logic d);
    tms_o = m;
    tdi_o = d;
    #7.5 tck_o = 1'b1;
    #7.5 tck_o = 1'b0;
  endtask

  // five highs reach reset from any state, then park in idle
  task automatic go_idle();
    repeat (5) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask

  // idle -> capture -> shift n bits lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [157:0] din);
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i]);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
endmodule

// *** sim/tb_jtag_tap_boundary_scan.sv ***
// self-checking bench for the test access port and its boundary scan chain
// assumes jtb_pkg and jtb_tap_top are compiled first; tck comes from the tester model
`timescale 1ns/1ps
module tb_jtag_tap_boundary_scan
  import jtb_pkg::*;
;
  // ****************************************************************
  // wiring
  // ****************************************************************
  // identity values are arbitrary
  localparam logic [3:0]  VER   = 4'h6;
  localparam logic [15:0] PART  = 16'h5a3c;
  localparam logic [10:0] MAKER = 11'h2d1;
  localparam logic [31:0] ID    = {VER, PART, MAKER, 1'b1};

  logic         core_clk = 1'b0;
  logic         rst_n    = 1'b0;
  logic         ce       = 1'b1;
  logic         trst_n   = 1'b0;
  logic         tck, tms, tdi, tdo, tdo_oe, extest, intest;
  logic [157:0] cap      = '0;
  logic [157:0] drv;
  logic         expq[$];
  int           n_mismatch      = 0;
  int           samples_checked = 0;
  int           cycles          = 0;
  logic [31:0]  seed            = 32'h59;

  jtb_tester u_tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  jtb_tap_top #(.ID_VER(VER), .ID_PART(PART), .ID_MAKER(MAKER)) uut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce), .tck_i(tck), .trst_n_i(trst_n),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .cell_capture_i(cap),
    .cell_drive_o(drv), .test_extest_o(extest), .test_intest_o(intest));

  always #5 core_clk = ~core_clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [157:0] rvec();
    logic [159:0] t;
    t = {rnd(), rnd(), rnd(), rnd(), rnd()};
    return t[157:0];
  endfunction

  task automatic check(input logic [157:0] seen, input logic [157:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // notes the bits due at tdo, then lets the tester shift them out
  task automatic run(input logic ir, input int n, input logic [157:0] din,
                     input logic [157:0] exp);
    for (int i = 0; i < n; i++) expq.push_back(exp[i]);
    u_tst.scan(ir, n, din);
    check(158'(expq.size()), 158'h0);
  endtask

  // core side needs a few enabled cycles to follow the tck domain
  task automatic settle();
    repeat (10) @(posedge core_clk);
    #1;
  endtask

  // tdo is only a result while the tap drives it
  always @(posedge tck) begin
    if (tdo_oe === 1'b1) begin
      if (expq.size() == 0) check(158'h1, 158'h0);
      else check(158'(tdo), 158'(expq.pop_front()));
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [157:0] a, b;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) u_tst.tick(1'b0, 1'b0);
    settle();
    check(158'(tdo_oe), 158'h0);
    check(drv, CELL_INIT);
    check(158'({extest, intest}), 158'h0);
    @(posedge core_clk) trst_n <= 1'b1;
    u_tst.tick(1'b0, 1'b1);
    run(1'b0, 32, '1, 158'(ID));
    $display("test reset and identification done");

    for (int c = 4; c < 8; c++) begin
      a = rvec();
      run(1'b1, 3, 158'(c), 158'h1);
      run(1'b0, 8, a, 158'({a[6:0], 1'b0}));
    end
    settle();
    check(158'({extest, intest}), 158'h0);
    u_tst.go_idle();
    run(1'b0, 32, '0, 158'(ID));
    run(1'b1, 3, 158'h3, 158'h1);
    run(1'b0, 32, '1, 158'(ID));
    $display("test bypass codes done");

    // capture-ir, exit1, update: internal test without passing shift-ir
    u_tst.tick(1'b1, 1'b1);
    u_tst.tick(1'b1, 1'b1);
    u_tst.tick(1'b0, 1'b1);
    u_tst.tick(1'b1, 1'b1);
    u_tst.tick(1'b1, 1'b1);
    u_tst.tick(1'b0, 1'b1);
    settle();
    check(158'({extest, intest}), 158'h1);
    $display("test internal mode done");

    @(posedge core_clk) cap <= rvec();
    a = rvec();
    run(1'b1, 3, 158'h0, 158'h1);
    settle();
    check(158'({extest, intest}), 158'h2);
    run(1'b0, 158, a, cap);
    settle();
    check(drv, a);
    @(posedge core_clk) ce <= 1'b0;
    b = rvec();
    run(1'b0, 158, b, cap);
    settle();
    check(drv, a);
    @(posedge core_clk) ce <= 1'b1;
    settle();
    check(drv, b);
    $display("test external scan done");

    // park in shift-dr so the test reset has a driven tdo and a live mode to clear
    u_tst.tick(1'b1, 1'b1);
    u_tst.tick(1'b0, 1'b1);
    u_tst.tick(1'b0, 1'b1);
    #1;
    check(158'(tdo_oe), 158'h1);
    @(posedge core_clk) trst_n <= 1'b0;
    #1;
    check(158'(tdo_oe), 158'h0);
    settle();
    check(158'({extest, intest}), 158'h0);
    @(posedge core_clk) trst_n <= 1'b1;
    u_tst.tick(1'b0, 1'b1);
    run(1'b0, 32, '1, 158'(ID));
    $display("test test reset done");
    finish_test();
  end
endmodule
